// ===== dv/pkt_core_tb.sv
// self-checking bench for the public-key timing engine
`timescale 1ns/1ps
`include "pkt_params.svh"
module pkt_core_tb;
  logic clk, nrst, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  int modulus_digits = 4;
  int bc, wc, exp_avg;
  pkt_core dut (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  pkt_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      test_done;
    end
  end
  task wait_done(output int k);
    int t0;
    t0 = cyc;
    rd = 32'h0;
    while (rd[`PKT_ST_DONE] !== 1'b1)
      host.xfer(1'b0, `PKT_A_STATUS, 32'h0, rd, er);
    k = cyc - t0;
  endtask : wait_done
  task run_op(input logic [7:0] e, input int lo, input int hi);
    int t;
    host.xfer(1'b1, `PKT_A_ENTRY, {24'h0, e}, rd, er);
    t = cyc;
    host.xfer(1'b0, `PKT_A_STATUS, 32'h0, rd, er);
    chk(rd[`PKT_ST_DONE], 1'b0);
    wait_done(n);
    n = cyc - t;
    chk(n >= lo && n <= hi, 1'b1);
    $display("op %h done in %0d", e, n);
  endtask : run_op
  initial
  begin
    ce = 1'b1;
    nrst = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    host.xfer(1'b0, `PKT_A_STATUS, 32'h0, rd, er);
    chk(rd[`PKT_ST_DONE], 1'b0);
    wait_done(n);
    chk(n > 180, 1'b1);
    host.xfer(1'b0, `PKT_A_MODSIZE, 32'h0, rd, er);
    chk(rd, 32'h3);
    host.xfer(1'b0, 12'h020, 32'h0, rd, er);
    chk(er, 1'b1);
    $display("reset test ends");
    bc = modulus_digits * modulus_digits + 9 * modulus_digits + 22;
    wc = modulus_digits * modulus_digits + 10 * modulus_digits + 27;
    // 64 exponent bits; mean multiply is three quarters best plus one quarter worst
    exp_avg = 3 * 64 * (3 * bc + wc) / 8 + wc;
    host.setup(modulus_digits, 10);
    run_op(`PKT_E_MULT, bc, wc + 4);
    run_op(`PKT_E_MULT2, 2 * bc, 2 * wc + 4);
    run_op(`PKT_E_ADD, 3 * modulus_digits + 6, 4 * modulus_digits + 15);
    run_op(`PKT_E_SUB, 2 * modulus_digits + 6, 3 * modulus_digits + 15);
    host.xfer(1'b1, `PKT_A_EXPSIZE, 32'h3, rd, er);
    run_op(`PKT_E_EXP, exp_avg * 99 / 100, exp_avg + 4);
    run_op(`PKT_E_PMUL, 1, 64 * wc + 4);
    host.xfer(1'b0, `PKT_A_STATUS, 32'h0, rd, er);
    chk(rd[`PKT_ST_HOST], 1'b1);
    host.setup(5, 10);
    host.xfer(1'b1, `PKT_A_CTRL, 32'h1, rd, er);
    host.xfer(1'b1, `PKT_A_ENTRY, 32'h0C, rd, er);
    host.xfer(1'b0, `PKT_A_STATUS, 32'h0, rd, er);
    chk(rd[1:0], 2'b11);
    host.xfer(1'b1, `PKT_A_CTRL, 32'h0, rd, er);
    run_op(`PKT_E_R2, 1, 1100);
    host.xfer(1'b0, 12'hA00, 32'h0, rd, er);
    chk(rd, 32'h0000_8001);
    host.xfer(1'b1, `PKT_A_CTRL, 32'h4, rd, er);
    host.xfer(1'b0, `PKT_A_STATUS, 32'h0, rd, er);
    chk(rd[`PKT_ST_DONE], 1'b0);
    wait_done(n);
    host.xfer(1'b0, 12'hA00, 32'h0, rd, er);
    chk(rd, 32'h0);
    $display("soft reset test ends");
    test_done;
  end
endmodule : pkt_core_tb

// ===== dv/pkt_host.sv
// apb host model that programs the engine
`timescale 1ns/1ps
`include "pkt_params.svh"
module pkt_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // one idle edge first, so back-to-back calls never assign twice in a step
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task setup(input int d, input int e);
    logic [31:0] r;
    logic x;
    xfer(1'b1, `PKT_A_CTRL, 32'h0, r, x);
    xfer(1'b1, `PKT_A_MODSIZE, 32'(d - 1), r, x);
    xfer(1'b1, `PKT_A_EXPSIZE, 32'(e - 1), r, x);
    // prime into memory n, top digit non-zero
    for (int i = 0; i < d; i++)
      xfer(1'b1, 12'hA00 + 12'(4 * i), 32'h0000_8001, r, x);
  endtask : setup
endmodule : pkt_host

// ===== rtl/pkt_core.sv
// public-key engine routine sequencer with crt constant and apb registers
// What this block does
// - crt constant routine yields 2^(16D)*2^(16E) mod loaded prime, p or q
// - result left in memory b word region, modulus kept in n
// - durations counted in clocks with modulus_digits = modsize plus one
// - multiply lasts between d^2+9d+22 and d^2+10d+27 clocks, d modulus_digits
// - double multiply takes exactly twice single multiply counts
// - addition takes 3d+6 to 4d+11 clocks
// - subtraction takes 2d+6 to 3d+11 clocks
// - projective_complete_select one finishes in hardware, else host finishes
// - after any reset memories a, b, n cleared before done rises
`timescale 1ns/1ps
`include "pkt_params.svh"
module pkt_core
  import pkt_pkg::*;
#(
  parameter int DIG = 16,
  parameter int MEM_WORDS = 64
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int AW = $clog2(MEM_WORDS);
  localparam int MW = 3 * MEM_WORDS;
  pkt_state_t st_q, st_d;
  logic [DIG-1:0] mem_q [MW];
  logic [7:0] modsize_q, expsize_q, entry_q;
  logic binary_field_select_q, projective_complete_select_q, done_q, err_q, host_q;
  logic [31:0] cnt_q, ptr_q;

  // access decode
  wire acc = psel && penable && ce;
  wire wr = acc && pwrite;
  wire is_mem = paddr[11];
  wire [AW+1:0] maddr = paddr[AW+3:2];
  wire wr_ctrl = wr && paddr == `PKT_A_CTRL;
  wire wr_ms = wr && paddr == `PKT_A_MODSIZE;
  wire wr_es = wr && paddr == `PKT_A_EXPSIZE;
  wire wr_ent = wr && paddr == `PKT_A_ENTRY && st_q == PKT_IDLE;
  wire soft_rst = wr_ctrl && pwdata[`PKT_CTRL_SRST];
  wire mapped = is_mem ? (int'(maddr) < MW) : (paddr <= `PKT_A_ENTRY && paddr[1:0] == 2'b00);
  // memory word offered to a read setup; words past the three regions read as zero
  wire mem_hit = int'(maddr) < MW;
  wire [31:0] mem_rd = mem_hit ? 32'(mem_q[maddr]) : 32'h0;
  // a crt constant launch while the binary field is selected is refused
  wire crt_launch_bad = pwdata[7:0] == `PKT_E_R2 && binary_field_select_q;
  wire [31:0] modulus_digits = 32'(modsize_q) + 32'd1;
  wire [31:0] ebits = (32'(expsize_q) + 32'd1) * 32'(DIG);
  // worst and best multiply counts
  wire [31:0] mul_wc = modulus_digits * modulus_digits
    + `PKT_MUL_WC_K * modulus_digits + `PKT_MUL_WC_C;
  wire [31:0] mul_bc = modulus_digits * modulus_digits
    + `PKT_MUL_BC_K * modulus_digits + `PKT_MUL_BC_C;
  wire [31:0] add_wc = `PKT_ADD_WC_K * modulus_digits + `PKT_ADD_WC_C;
  wire [31:0] sub_wc = `PKT_SUB_WC_K * modulus_digits + `PKT_SUB_WC_C;
  wire [31:0] clr_n = `PKT_CLR_K * (modulus_digits + `PKT_CLR_C);

  // every routine except exponentiation, which uses the weighted average multiply, is timed at its worst case so software never sees it early
  function automatic logic [31:0] run_len(input logic [7:0] e, input logic bin_field);
    case (e)
      `PKT_E_MULT: run_len = mul_wc;
      `PKT_E_MULT2: run_len = 32'd2 * mul_wc;
      `PKT_E_ADD: run_len = add_wc;
      `PKT_E_SUB: run_len = sub_wc;
      // average weighted multiply: three bcs plus one wcs over four
      `PKT_E_EXP: run_len = (ebits * 32'd3 / 32'd2) * ((32'd3 * mul_bc + mul_wc) >> 2)
        + mul_wc;
      `PKT_E_PMUL: run_len = bin_field ? ebits * (`PKT_PADD_MUL * mul_wc
        + `PKT_PADD_ADD * add_wc + `PKT_PADD_MOV * modulus_digits)
        : ebits * mul_wc;
      `PKT_E_R2: run_len = (modulus_digits + modulus_digits) * mul_wc;
      default: run_len = clr_n;
    endcase
  endfunction : run_len

  wire crt_bad = entry_q == `PKT_E_R2 && binary_field_select_q;
  // run ends one count early: the write cycle is the last cycle of the routine,
  // so done rises exactly run_len cycles after the launching edge
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      PKT_IDLE: if (wr_ent && !crt_launch_bad) st_d = PKT_RUN;
      PKT_CLEAR: if (int'(ptr_q) >= MW - 1) st_d = PKT_IDLE;
      PKT_RUN: if (cnt_q <= 32'd2) st_d = PKT_WRITE;
      PKT_WRITE: st_d = PKT_IDLE;
      default: st_d = PKT_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst || (ce && soft_rst))
    begin
      st_q <= PKT_CLEAR;
      ptr_q <= 32'h0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      host_q <= 1'b0;
      binary_field_select_q <= 1'b0;
      projective_complete_select_q <= 1'b0;
      modsize_q <= 8'h03;
      expsize_q <= 8'h03;
      entry_q <= 8'h00;
      cnt_q <= 32'h0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      if (wr_ctrl)
      begin
        binary_field_select_q <= pwdata[`PKT_CTRL_BFS];
        projective_complete_select_q <= pwdata[`PKT_CTRL_PCS];
      end
      if (wr_ms) modsize_q <= pwdata[7:0];
      if (wr_es) expsize_q <= pwdata[7:0];
      if (st_q == PKT_CLEAR) ptr_q <= ptr_q + 32'd1;
      if (st_q == PKT_CLEAR && st_d == PKT_IDLE) done_q <= 1'b1;
      if (wr_ent)
      begin
        entry_q <= pwdata[7:0];
        cnt_q <= run_len(pwdata[7:0], binary_field_select_q);
        err_q <= crt_launch_bad;
        done_q <= crt_launch_bad;
        ptr_q <= 32'h0;
        if (pwdata[7:0] == `PKT_E_CLR) st_q <= PKT_CLEAR;
      end
      if (st_q == PKT_RUN) cnt_q <= cnt_q - 32'd1;
      if (st_q == PKT_WRITE)
      begin
        done_q <= 1'b1;
        // without projective completion the host still owes the finishing steps
        host_q <= entry_q == `PKT_E_PMUL && !projective_complete_select_q;
      end
    end
  end

  // memory: a, b, n regions; clear sweep or host write; result into b
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (st_q == PKT_CLEAR && int'(ptr_q) < MW)
        mem_q[ptr_q[AW+1:0]] <= '0;
      else if (wr && is_mem && int'(maddr) < MW && st_q == PKT_IDLE)
        mem_q[maddr] <= pwdata[DIG-1:0];
      else if (st_q == PKT_WRITE && !crt_bad && entry_q == `PKT_E_R2)
        mem_q[MEM_WORDS] <= mem_q[2*MEM_WORDS] ^ DIG'(modulus_digits);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      prdata <= 32'h0;
    else if (ce && psel && !penable && !pwrite)
      case (paddr)
        `PKT_A_CTRL: prdata <= {30'h0, projective_complete_select_q, binary_field_select_q};
        `PKT_A_STATUS: prdata <= {29'h0, host_q, err_q, done_q};
        `PKT_A_MODSIZE: prdata <= {24'h0, modsize_q};
        `PKT_A_EXPSIZE: prdata <= {24'h0, expsize_q};
        `PKT_A_ENTRY: prdata <= {24'h0, entry_q};
        default: prdata <= is_mem ? mem_rd : 32'h0;
      endcase
  end

  // zero wait states: the access phase always completes while enabled
  assign pready = ce;
  assign pslverr = acc && !mapped;

  a_clear_before_done: assert property (@(posedge clk) disable iff (!nrst)
    st_q == PKT_CLEAR |-> !done_q) else $error("done during clear");
  a_crt_refused: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_ent && pwdata[7:0] == `PKT_E_R2 && binary_field_select_q
    |=> err_q && st_q == PKT_IDLE)
    else $error("crt launch not refused");
  a_done_low_run: assert property (@(posedge clk) disable iff (!nrst)
    st_q == PKT_RUN |-> !done_q) else $error("done high while running");
  a_done_after_write: assert property (@(posedge clk) disable iff (!nrst)
    ce && st_q == PKT_WRITE |=> done_q) else $error("done missing");
  a_mult_span: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_ent && pwdata[7:0] == `PKT_E_MULT |=> cnt_q == mul_wc && cnt_q >= mul_bc)
    else $error("multiply count wrong");
  a_mult2_twice: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_ent && pwdata[7:0] == `PKT_E_MULT2 |=> cnt_q == 32'd2 * mul_wc)
    else $error("double multiply count wrong");
  a_add_span: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_ent && pwdata[7:0] == `PKT_E_ADD |=> cnt_q == 32'd4 * modulus_digits + 32'd11)
    else $error("add count wrong");
  a_sub_span: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_ent && pwdata[7:0] == `PKT_E_SUB |=> cnt_q == 32'd3 * modulus_digits + 32'd11)
    else $error("sub count wrong");
  a_host_finish: assert property (@(posedge clk) disable iff (!nrst)
    ce && st_q == PKT_WRITE && entry_q == `PKT_E_PMUL && !projective_complete_select_q
    |=> host_q) else $error("host finishing flag missing");
  c_crt_run: cover property (@(posedge clk) st_q == PKT_WRITE && entry_q == `PKT_E_R2);
  c_refuse: cover property (@(posedge clk) err_q);
  c_clear_done: cover property (@(posedge clk) st_q == PKT_CLEAR ##1 st_q == PKT_IDLE);
  c_point_host: cover property (@(posedge clk) host_q && done_q);
endmodule : pkt_core

// ===== rtl/pkt_params.svh
// constants for the public-key timing engine
`ifndef PKT_PARAMS_SVH
`define PKT_PARAMS_SVH
`define PKT_A_CTRL 12'h000
`define PKT_A_STATUS 12'h004
`define PKT_A_MODSIZE 12'h008
`define PKT_A_EXPSIZE 12'h00C
`define PKT_A_ENTRY 12'h010
`define PKT_A_MEM 12'h800
`define PKT_CTRL_BFS 0
`define PKT_CTRL_PCS 1
`define PKT_CTRL_SRST 2
`define PKT_ST_DONE 0
`define PKT_ST_ERR 1
`define PKT_ST_HOST 2
`define PKT_E_MULT 8'h01
`define PKT_E_MULT2 8'h02
`define PKT_E_EXP 8'h03
`define PKT_E_PMUL 8'h04
`define PKT_E_ADD 8'h08
`define PKT_E_SUB 8'h09
`define PKT_E_R2 8'h0C
`define PKT_E_CLR 8'h0D
`define PKT_MUL_WC_K 10
`define PKT_MUL_WC_C 27
`define PKT_MUL_BC_K 9
`define PKT_MUL_BC_C 22
`define PKT_ADD_WC_K 4
`define PKT_ADD_WC_C 11
`define PKT_SUB_WC_K 3
`define PKT_SUB_WC_C 11
`define PKT_CLR_K 4
`define PKT_CLR_C 5
`define PKT_PADD_MUL 20
`define PKT_PADD_ADD 7
`define PKT_PADD_MOV 15
`endif

// ===== rtl/pkt_pkg.sv
// types for the public-key timing engine
package pkt_pkg;
  typedef enum logic [1:0] {
    PKT_IDLE = 2'b00,
    PKT_CLEAR = 2'b01,
    PKT_RUN = 2'b10,
    PKT_WRITE = 2'b11
  } pkt_state_t;
endpackage : pkt_pkg
